// [rtl/tdms_top.sv]
// Summary of operation
// - motoring limit applies both directions when motoring
// - regen limit applies both directions when regenerating
// - lower symmetrical limit replaces larger limit
// - offset added only when offset enable set
// - analog offset refreshed once per 4 ms
// - open loop, selector 0: normal frequency path
// - open loop, selector 1: current pi control
// - pi sum of error terms forms frequency reference
// - pi output clamped to max speed frequency
// - rotor flux torque mode bypasses ramps while running
// - leaving run undisabled starts configured stop mode
// - rotor flux torque mode ramp stop preloads ramp with measured speed
// - speed mode: demand is speed loop output
// - torque mode: reference plus enabled offset
`timescale 1ns/1ps
`include "tdms_defs.svh"
module tdms_top #(
  parameter int unsigned TICK_CYCLES = `TDMS_TICK_MS * 1000 * `TDMS_CLK_MHZ
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // register port
  input wire logic [`TDMS_ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // drive state and measurements
  input wire logic i_run,
  input wire logic i_disabled,
  input wire logic i_stopped,
  input wire logic i_regen,
  input wire logic signed [15:0] i_speed_loop_out,
  input wire logic signed [15:0] i_measured_speed,
  input wire logic signed [15:0] i_active_current,
  input wire logic signed [15:0] i_analog_offset,
  input wire logic signed [15:0] i_ramp_freq,
  // demands
  output logic signed [15:0] o_torque_demand,
  output logic signed [15:0] o_current_demand,
  output logic [15:0] o_current_limit,
  output logic signed [15:0] o_freq_ref,
  // ramp and stop control
  output logic o_ramp_bypass,
  output logic o_stop_start,
  output logic [1:0] o_stop_mode,
  output logic o_ramp_preload,
  output logic signed [15:0] o_ramp_preload_value
);
  tdms_pkg::tdms_cfg_t cfg_q;
  tdms_pkg::tdms_cfg_t cfg_d;
  tdms_pkg::tdms_sample_t smp_q;
  tdms_pkg::tdms_sample_t smp_d;
  tdms_pkg::tdms_state_t st_q;
  tdms_pkg::tdms_state_t st_d;
  logic [31:0] tick_cnt_q;
  logic [31:0] tick_cnt_d;
  logic tick;
  logic [31:0] rdata_d;
  logic signed [15:0] demand_d;
  logic signed [15:0] cur_d;
  logic signed [15:0] clamped;
  logic [15:0] limit;
  logic signed [15:0] pi_freq;
  logic signed [15:0] freq_d;
  logic signed [16:0] torque_sum;
  logic signed [15:0] ofs_term;
  logic signed [16:0] cur_err;
  logic signed [15:0] err_sat;
  logic pi_en;
  logic bypass_d;
  logic stop_start_d;
  logic preload_d;
  logic [1:0] stop_mode_d;
  logic signed [15:0] preload_val_d;
  logic torque_mode;

  // background tick; a shortened parameter speeds simulation
  always_comb begin
    tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));
    tick_cnt_d = tick ? 32'h00000000 : tick_cnt_q + 32'h00000001;
  end

  // register writes
  always_comb begin
    cfg_d = cfg_q;
    if (i_wr) begin
      case (i_addr)
        `TDMS_OFS_TORQUE_REF: begin
          cfg_d.torque_reference_value = i_wdata[15:0];
        end
        `TDMS_OFS_TORQUE_OFS: begin
          cfg_d.torque_offset_value = i_wdata[15:0];
        end
        `TDMS_OFS_OFS_ENABLE: begin
          cfg_d.torque_offset_enable = i_wdata[0];
        end
        `TDMS_OFS_MODE_SEL: begin
          cfg_d.torque_mode_selector = i_wdata[0];
        end
        `TDMS_OFS_CONTROL: begin
          cfg_d.rotor_flux_control_mode = i_wdata[`TDMS_CTL_RFC];
          cfg_d.offset_from_analog = i_wdata[`TDMS_CTL_ANALOG];
          cfg_d.stop_mode =
            tdms_pkg::tdms_stop_t'(i_wdata[`TDMS_CTL_STOP_HI:`TDMS_CTL_STOP_LO]);
        end
        `TDMS_OFS_MOT_LIMIT: begin
          cfg_d.mot_limit = i_wdata[15:0];
        end
        `TDMS_OFS_REGEN_LIMIT: begin
          cfg_d.regen_limit = i_wdata[15:0];
        end
        `TDMS_OFS_SYM_LIMIT: begin
          cfg_d.sym_limit = i_wdata[15:0];
        end
        `TDMS_OFS_FREQ_MAX: begin
          cfg_d.max_speed_frequency_limit = i_wdata[15:0];
        end
        `TDMS_OFS_KP: begin
          cfg_d.kp = i_wdata[15:0];
        end
        `TDMS_OFS_KI: begin
          cfg_d.ki = i_wdata[15:0];
        end
        default: begin
          cfg_d = cfg_q;
        end
      endcase
    end
  end

  // register reads, data one cycle after the strobe
  always_comb begin
    rdata_d = 32'h00000000;
    if (i_rd) begin
      case (i_addr)
        `TDMS_OFS_TORQUE_REF: rdata_d = {16'h0000, cfg_q.torque_reference_value};
        `TDMS_OFS_TORQUE_OFS: rdata_d = {16'h0000, cfg_q.torque_offset_value};
        `TDMS_OFS_OFS_ENABLE: rdata_d = {31'h00000000, cfg_q.torque_offset_enable};
        `TDMS_OFS_MODE_SEL: rdata_d = {31'h00000000, cfg_q.torque_mode_selector};
        `TDMS_OFS_CONTROL: rdata_d = {28'h0000000, cfg_q.stop_mode,
          cfg_q.offset_from_analog, cfg_q.rotor_flux_control_mode};
        `TDMS_OFS_MOT_LIMIT: rdata_d = {16'h0000, cfg_q.mot_limit};
        `TDMS_OFS_REGEN_LIMIT: rdata_d = {16'h0000, cfg_q.regen_limit};
        `TDMS_OFS_SYM_LIMIT: rdata_d = {16'h0000, cfg_q.sym_limit};
        `TDMS_OFS_FREQ_MAX: rdata_d = {16'h0000, cfg_q.max_speed_frequency_limit};
        `TDMS_OFS_KP: rdata_d = {16'h0000, cfg_q.kp};
        `TDMS_OFS_KI: rdata_d = {16'h0000, cfg_q.ki};
        `TDMS_OFS_DEMAND: rdata_d = {o_current_demand, o_torque_demand};
        `TDMS_OFS_STATUS: rdata_d = {13'h0000, o_current_limit, st_q, o_ramp_bypass};
        `TDMS_OFS_FREQ_REF: rdata_d = {16'h0000, o_freq_ref};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  // torque reference, offset, offset enable and mode selector take effect at the tick, so a write to them lands up to 4 ms late
  always_comb begin
    smp_d = smp_q;
    if (tick) begin
      smp_d.torque_ref = cfg_q.torque_reference_value;
      smp_d.torque_ofs = cfg_q.offset_from_analog ? i_analog_offset
                                                  : cfg_q.torque_offset_value;
      smp_d.ofs_enable = cfg_q.torque_offset_enable;
      smp_d.mode_sel = cfg_q.torque_mode_selector;
    end
  end

  // torque demand selection
  always_comb begin
    torque_mode = smp_q.mode_sel;
    ofs_term = smp_q.ofs_enable ? signed'(smp_q.torque_ofs) : 16'sh0000;
    torque_sum = 17'(signed'(smp_q.torque_ref)) + 17'(ofs_term);
    if (!torque_mode) begin
      demand_d = i_speed_loop_out;
    end else if (torque_sum > 17'sh07fff) begin
      demand_d = 16'sh7fff;
    end else if (torque_sum < -17'sh08000) begin
      demand_d = -16'sh8000;
    end else begin
      demand_d = 16'(torque_sum);
    end
    cur_d = clamped;
  end

  tdms_limit u_limit (
    .i_mot_limit(cfg_q.mot_limit),
    .i_regen_limit(cfg_q.regen_limit),
    .i_sym_limit(cfg_q.sym_limit),
    .i_regen(i_regen),
    .i_demand(o_torque_demand),
    .o_limit(limit),
    .o_clamped(clamped)
  );

  // open-loop current control
  always_comb begin
    pi_en = !cfg_q.rotor_flux_control_mode && torque_mode;
    cur_err = 17'(o_current_demand) - 17'(i_active_current);
    if (cur_err > 17'sh07fff) begin
      err_sat = 16'sh7fff;
    end else if (cur_err < -17'sh08000) begin
      err_sat = -16'sh8000;
    end else begin
      err_sat = 16'(cur_err);
    end
    freq_d = pi_en ? pi_freq : i_ramp_freq;
  end

  tdms_pi u_pi (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_enable(pi_en),
    .i_error(err_sat),
    .i_kp(cfg_q.kp),
    .i_ki(cfg_q.ki),
    .i_fmax(cfg_q.max_speed_frequency_limit),
    .o_freq(pi_freq)
  );

  // run and stop sequencing in every mode, with ramp bypass and preload for the rotor-flux path
  always_comb begin
    st_d = st_q;
    stop_start_d = 1'b0;
    preload_d = 1'b0;
    stop_mode_d = o_stop_mode;
    preload_val_d = o_ramp_preload_value;
    case (st_q)
      tdms_pkg::TDMS_ST_IDLE: begin
        if (i_run && !i_disabled) begin
          st_d = tdms_pkg::TDMS_ST_RUN;
        end
      end
      tdms_pkg::TDMS_ST_RUN: begin
        if (i_disabled) begin
          st_d = tdms_pkg::TDMS_ST_IDLE;
        end else if (!i_run) begin
          st_d = tdms_pkg::TDMS_ST_STOP;
          stop_start_d = 1'b1;
          stop_mode_d = cfg_q.stop_mode;
          // coast or no-ramp is preferred; ramp stop needs a bumpless start
          if (cfg_q.rotor_flux_control_mode && torque_mode &&
              cfg_q.stop_mode == tdms_pkg::TDMS_STOP_RAMP) begin
            preload_d = 1'b1;
            preload_val_d = i_measured_speed;
          end
        end
      end
      tdms_pkg::TDMS_ST_STOP: begin
        if (i_disabled || i_stopped) begin
          st_d = tdms_pkg::TDMS_ST_IDLE;
        end else if (i_run) begin
          st_d = tdms_pkg::TDMS_ST_RUN;
        end
      end
      default: begin
        st_d = tdms_pkg::TDMS_ST_IDLE;
      end
    endcase
    bypass_d = cfg_q.rotor_flux_control_mode && torque_mode &&
               (st_d == tdms_pkg::TDMS_ST_RUN);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tick_cnt_q <= 32'h00000000;
      cfg_q.torque_reference_value <= `TDMS_RST_TORQUE_REF;
      cfg_q.torque_offset_value <= `TDMS_RST_TORQUE_OFS;
      cfg_q.torque_offset_enable <= `TDMS_RST_OFS_ENABLE;
      cfg_q.torque_mode_selector <= `TDMS_RST_MODE_SEL;
      cfg_q.rotor_flux_control_mode <= 1'b0;
      cfg_q.offset_from_analog <= 1'b0;
      cfg_q.stop_mode <= tdms_pkg::TDMS_STOP_COAST;
      cfg_q.mot_limit <= `TDMS_RST_LIMIT;
      cfg_q.regen_limit <= `TDMS_RST_LIMIT;
      cfg_q.sym_limit <= `TDMS_RST_LIMIT;
      cfg_q.max_speed_frequency_limit <= `TDMS_RST_FREQ_MAX;
      cfg_q.kp <= `TDMS_RST_KP;
      cfg_q.ki <= `TDMS_RST_KI;
      smp_q.torque_ref <= `TDMS_RST_TORQUE_REF;
      smp_q.torque_ofs <= `TDMS_RST_TORQUE_OFS;
      smp_q.ofs_enable <= `TDMS_RST_OFS_ENABLE;
      smp_q.mode_sel <= `TDMS_RST_MODE_SEL;
      st_q <= tdms_pkg::TDMS_ST_IDLE;
      o_rdata <= 32'h00000000;
      o_torque_demand <= 16'sh0000;
      o_current_demand <= 16'sh0000;
      o_current_limit <= 16'h0000;
      o_freq_ref <= 16'sh0000;
      o_ramp_bypass <= 1'b0;
      o_stop_start <= 1'b0;
      o_stop_mode <= 2'b00;
      o_ramp_preload <= 1'b0;
      o_ramp_preload_value <= 16'sh0000;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      cfg_q <= cfg_d;
      smp_q <= smp_d;
      st_q <= st_d;
      o_rdata <= rdata_d;
      o_torque_demand <= demand_d;
      o_current_demand <= cur_d;
      o_current_limit <= limit;
      o_freq_ref <= freq_d;
      o_ramp_bypass <= bypass_d;
      o_stop_start <= stop_start_d;
      o_stop_mode <= stop_mode_d;
      o_ramp_preload <= preload_d;
      o_ramp_preload_value <= preload_val_d;
    end
  end
endmodule

// [rtl/tdms_defs.svh]
// constants for the torque demand and mode select block
`ifndef TDMS_DEFS_SVH
`define TDMS_DEFS_SVH

// register offsets, byte addresses
`define TDMS_ADDR_W 8
`define TDMS_OFS_TORQUE_REF 8'h00
`define TDMS_OFS_TORQUE_OFS 8'h04
`define TDMS_OFS_OFS_ENABLE 8'h08
`define TDMS_OFS_MODE_SEL 8'h0c
`define TDMS_OFS_CONTROL 8'h10
`define TDMS_OFS_MOT_LIMIT 8'h14
`define TDMS_OFS_REGEN_LIMIT 8'h18
`define TDMS_OFS_SYM_LIMIT 8'h1c
`define TDMS_OFS_FREQ_MAX 8'h20
`define TDMS_OFS_KP 8'h24
`define TDMS_OFS_KI 8'h28
`define TDMS_OFS_DEMAND 8'h2c
`define TDMS_OFS_STATUS 8'h30
`define TDMS_OFS_FREQ_REF 8'h34

// control register fields
`define TDMS_CTL_RFC 0
`define TDMS_CTL_ANALOG 1
`define TDMS_CTL_STOP_LO 2
`define TDMS_CTL_STOP_HI 3

// reset values
`define TDMS_RST_TORQUE_REF 16'h0000
`define TDMS_RST_TORQUE_OFS 16'h0000
`define TDMS_RST_OFS_ENABLE 1'b0
`define TDMS_RST_MODE_SEL 1'b0
`define TDMS_RST_LIMIT 16'h7fff
`define TDMS_RST_FREQ_MAX 16'h7fff
`define TDMS_RST_KP 16'h0014
`define TDMS_RST_KI 16'h0028

// background tick and loop scaling
`define TDMS_TICK_MS 4
`define TDMS_CLK_MHZ 250
`define TDMS_KP_SHIFT 8
`define TDMS_KI_SHIFT 16

`endif

// [rtl/tdms_pkg.sv]
// types for the torque demand and mode select block
package tdms_pkg;

  typedef enum logic [1:0] {
    TDMS_STOP_COAST = 2'b00,
    TDMS_STOP_RAMP = 2'b01,
    TDMS_STOP_NO_RAMP = 2'b10
  } tdms_stop_t;

  typedef enum logic [1:0] {
    TDMS_ST_IDLE = 2'b00,
    TDMS_ST_RUN = 2'b01,
    TDMS_ST_STOP = 2'b10
  } tdms_state_t;

  // software-written configuration
  typedef struct packed {
    logic [15:0] torque_reference_value;
    logic [15:0] torque_offset_value;
    logic torque_offset_enable;
    logic torque_mode_selector;
    logic rotor_flux_control_mode;
    logic offset_from_analog;
    tdms_stop_t stop_mode;
    logic [15:0] mot_limit;
    logic [15:0] regen_limit;
    logic [15:0] sym_limit;
    logic [15:0] max_speed_frequency_limit;
    logic [15:0] kp;
    logic [15:0] ki;
  } tdms_cfg_t;

  // values taken on the background tick
  typedef struct packed {
    logic [15:0] torque_ref;
    logic [15:0] torque_ofs;
    logic ofs_enable;
    logic mode_sel;
  } tdms_sample_t;

endpackage

// [rtl/tdms_limit.sv]
// current limit selection and demand clamp
`timescale 1ns/1ps
`include "tdms_defs.svh"
module tdms_limit (
  // limits, unsigned magnitudes
  input wire logic [15:0] i_mot_limit,
  input wire logic [15:0] i_regen_limit,
  input wire logic [15:0] i_sym_limit,
  // operating quadrant and demand
  input wire logic i_regen,
  input wire logic signed [15:0] i_demand,
  // results
  output logic [15:0] o_limit,
  output logic signed [15:0] o_clamped
);
  logic [15:0] dir_lim;
  logic signed [16:0] pos;
  logic signed [16:0] neg;

  always_comb begin
    // quadrant picks the limit, direction of rotation does not matter
    dir_lim = i_regen ? i_regen_limit : i_mot_limit;
    o_limit = (i_sym_limit < dir_lim) ? i_sym_limit : dir_lim;
    pos = signed'({1'b0, o_limit});
    neg = -pos;
    if (17'(i_demand) > pos) begin
      o_clamped = 16'(pos);
    end else if (17'(i_demand) < neg) begin
      o_clamped = 16'(neg);
    end else begin
      o_clamped = i_demand;
    end
  end
endmodule

// [rtl/tdms_pi.sv]
// current pi controller producing a clamped frequency reference
`timescale 1ns/1ps
`include "tdms_defs.svh"
module tdms_pi (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // control
  input wire logic i_enable,
  input wire logic signed [15:0] i_error,
  input wire logic [15:0] i_kp,
  input wire logic [15:0] i_ki,
  input wire logic [15:0] i_fmax,
  // result
  output logic signed [15:0] o_freq
);
  logic signed [31:0] integ_q;
  logic signed [31:0] integ_d;
  logic signed [15:0] freq_d;
  logic signed [32:0] prop;
  logic signed [32:0] incr;
  logic signed [33:0] sum;
  logic signed [33:0] lim;

  always_comb begin
    prop = (33'(i_error) * signed'({17'h00000, i_kp})) >>> `TDMS_KP_SHIFT;
    incr = (33'(i_error) * signed'({17'h00000, i_ki})) >>> `TDMS_KI_SHIFT;
    lim = signed'({18'h00000, i_fmax});
    sum = 34'(prop) + 34'(integ_q);
    integ_d = integ_q;
    freq_d = o_freq;
    if (!i_enable) begin
      integ_d = 32'h00000000;
      freq_d = 16'h0000;
    end else begin
      // integrator held at the clamp so it cannot wind up
      if ((sum < lim) && (sum > -lim)) begin
        integ_d = 32'(34'(integ_q) + 34'(incr));
      end
      if (sum > lim) begin
        freq_d = 16'(lim);
      end else if (sum < -lim) begin
        freq_d = 16'(-lim);
      end else begin
        freq_d = 16'(sum);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      integ_q <= 32'h00000000;
      o_freq <= 16'h0000;
    end else begin
      integ_q <= integ_d;
      o_freq <= freq_d;
    end
  end
endmodule

// [test/tdms_top_chk.sv]
// port assertions for the torque demand block
`timescale 1ns/1ps
module tdms_top_chk (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // drive state
  input wire logic i_run,
  input wire logic i_disabled,
  input wire logic signed [15:0] i_measured_speed,
  // demands and stop control
  input wire logic signed [15:0] o_current_demand,
  input wire logic [15:0] o_current_limit,
  input wire logic o_ramp_bypass,
  input wire logic o_stop_start,
  input wire logic [1:0] o_stop_mode,
  input wire logic o_ramp_preload,
  input wire logic signed [15:0] o_ramp_preload_value
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // 17 bits so a full-scale limit never wraps when negated
  logic signed [16:0] lim_s;
  assign lim_s = $signed({1'b0, o_current_limit});
  limit_clamp_a: assert property (
    $signed(o_current_demand) <= lim_s && $signed(o_current_demand) >= -lim_s)
    else $error("current demand outside active limit");
  stop_cause_a: assert property (
    o_stop_start |-> $past(i_run, 2) && !$past(i_run) && !$past(i_disabled))
    else $error("stop started without leaving run");
  stop_pulse_a: assert property (o_stop_start |=> !o_stop_start)
    else $error("stop start longer than one cycle");
  preload_mode_a: assert property (
    o_ramp_preload |-> o_stop_start && o_stop_mode == tdms_pkg::TDMS_STOP_RAMP)
    else $error("preload outside a ramp stop");
  preload_value_a: assert property (
    o_ramp_preload |-> o_ramp_preload_value == $past(i_measured_speed))
    else $error("preload value is not measured speed");
  preload_taken_a: assert property (
    o_stop_start && o_stop_mode == tdms_pkg::TDMS_STOP_RAMP && $past(o_ramp_bypass)
    |-> o_ramp_preload)
    else $error("ramp stop from torque mode without preload");
  bypass_run_a: assert property (
    o_ramp_bypass |-> $past(i_run) && !$past(i_disabled))
    else $error("ramps bypassed outside run");
  bypass_stop_a: assert property (o_stop_start |-> !o_ramp_bypass)
    else $error("ramps still bypassed while stopping");
  bypass_hold_a: assert property (
    o_ramp_bypass && i_run && !i_disabled |=> o_ramp_bypass)
    else $error("bypass dropped while running");
  cover property (o_ramp_preload);
  cover property (o_stop_start && o_stop_mode == 2'h0);
  cover property (o_ramp_bypass ##1 !o_ramp_bypass);
endmodule

// [test/tdms_motor_model.sv]
// behavioural motor and power stage behind the inverter
`timescale 1ns/1ps
module tdms_motor_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // load behaviour
  input wire logic i_slow,
  input wire logic i_overhaul,
  // from the drive
  input wire logic signed [15:0] i_freq_ref,
  input wire logic signed [15:0] i_torque_demand,
  input wire logic i_stop_start,
  input wire logic i_run,
  // measurements
  output logic o_regen,
  output logic signed [15:0] o_active_current,
  output logic signed [15:0] o_measured_speed,
  output logic o_stopped
);
  logic signed [15:0] cur_q, cur_d, spd_q, spd_d, tgt;
  logic [3:0] cnt_q, cnt_d;
  logic stp_q, stp_d;
  always_comb begin
    // slip current follows frequency; slow load creeps one step a cycle
    tgt = i_freq_ref >>> 2;
    cur_d = tgt;
    if (i_slow && tgt > cur_q) begin
      cur_d = cur_q + 16'sh0001;
    end else if (i_slow && tgt < cur_q) begin
      cur_d = cur_q - 16'sh0001;
    end
    spd_d = spd_q + (i_torque_demand >>> 4);
    cnt_d = cnt_q;
    stp_d = stp_q && !i_run;
    if (i_stop_start) begin
      cnt_d = 4'h8;
    end else if (cnt_q != 4'h0) begin
      cnt_d = cnt_q - 4'h1;
      stp_d = (cnt_q == 4'h1);
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cur_q <= 16'sh0000;
      spd_q <= 16'sh0000;
      cnt_q <= 4'h0;
      stp_q <= 1'b0;
    end else begin
      cur_q <= cur_d;
      spd_q <= spd_d;
      cnt_q <= cnt_d;
      stp_q <= stp_d;
    end
  end
  assign o_regen = i_overhaul;
  assign o_active_current = cur_q;
  assign o_measured_speed = spd_q;
  assign o_stopped = stp_q;
endmodule

// [test/tdms_top_test.sv]
// self-checking bench for the torque demand block
`timescale 1ns/1ps
`include "tdms_defs.svh"
module tdms_top_test;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [`TDMS_ADDR_W-1:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_run = 1'b0;
  logic i_disabled = 1'b0;
  logic slow = 1'b0;
  logic overhaul = 1'b0;
  logic signed [15:0] i_speed_loop_out = 16'sh0123;
  logic signed [15:0] i_analog_offset = 16'sh0010;
  logic signed [15:0] i_ramp_freq = 16'sh0200;
  logic signed [15:0] i_measured_speed, i_active_current, spd_prev;
  logic i_stopped, i_regen;
  logic [31:0] o_rdata;
  logic signed [15:0] o_torque_demand, o_current_demand, o_freq_ref, o_ramp_preload_value;
  logic [15:0] o_current_limit;
  logic o_ramp_bypass, o_stop_start, o_ramp_preload;
  logic [1:0] o_stop_mode;
  int n_errors = 0;
  int samples_checked = 0;
  always #2 i_clk = ~i_clk;
  always @(posedge i_clk) spd_prev <= i_measured_speed;
  tdms_top #(.TICK_CYCLES(16)) u_tdms_top (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_run, .i_disabled, .i_stopped, .i_regen, .i_speed_loop_out, .i_measured_speed,
    .i_active_current, .i_analog_offset, .i_ramp_freq, .o_torque_demand, .o_current_demand,
    .o_current_limit, .o_freq_ref, .o_ramp_bypass, .o_stop_start, .o_stop_mode,
    .o_ramp_preload, .o_ramp_preload_value);
  tdms_motor_model u_tdms_motor_model (.i_clk, .i_rst, .i_slow(slow), .i_overhaul(overhaul),
    .i_freq_ref(o_freq_ref), .i_torque_demand(o_torque_demand), .i_stop_start(o_stop_start),
    .i_run, .o_regen(i_regen), .o_active_current(i_active_current),
    .o_measured_speed(i_measured_speed), .o_stopped(i_stopped));
  task automatic stop_test();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 check(name, o_rdata, exp);
  endtask
  // sampled torque settings only move on the tick, so wait past two of them
  task automatic settle();
    repeat (40) @(posedge i_clk);
    #1;
  endtask
  task automatic wait_stop(input int m);
    int k;
    for (k = 0; k < 20 && o_stop_start !== 1'b1; k++) begin
      @(posedge i_clk);
      #1;
    end
    if (k == 20) begin
      n_errors++;
      stop_test();
    end
    check("stop_mode", 32'(o_stop_mode), 32'(m));
    check("preload", 32'(o_ramp_preload), 32'(m == 1));
    if (m == 1) check("preload_val", 32'(o_ramp_preload_value), 32'(spd_prev));
    check("bypass_off", 32'(o_ramp_bypass), 32'h0);
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(`TDMS_OFS_OFS_ENABLE, 32'h0, "ofs_enable");
    rd(`TDMS_OFS_MODE_SEL, 32'h0, "mode_sel");
    rd(`TDMS_OFS_MOT_LIMIT, 32'h7fff, "mot_limit");
    rd(8'hfc, 32'h0, "unmapped");
    settle();
    check("speed_mode", 32'(o_torque_demand), 32'h0123);
    wr(`TDMS_OFS_TORQUE_REF, 32'h64);
    wr(`TDMS_OFS_TORQUE_OFS, 32'h14);
    wr(`TDMS_OFS_MODE_SEL, 32'h1);
    settle();
    check("ofs_off", 32'(o_torque_demand), 32'h64);
    wr(`TDMS_OFS_OFS_ENABLE, 32'h1);
    settle();
    check("ofs_on", 32'(o_torque_demand), 32'h78);
    wr(`TDMS_OFS_TORQUE_REF, 32'h7ff0);
    wr(`TDMS_OFS_TORQUE_OFS, 32'h0100);
    settle();
    check("sat", 32'(o_torque_demand), 32'h7fff);
    wr(`TDMS_OFS_TORQUE_REF, 32'hff38);
    wr(`TDMS_OFS_TORQUE_OFS, 32'h14);
    wr(`TDMS_OFS_MOT_LIMIT, 32'h32);
    wr(`TDMS_OFS_REGEN_LIMIT, 32'h50);
    settle();
    check("mot_lim", 32'(o_current_demand), 32'hffffffce);
    rd(`TDMS_OFS_DEMAND, 32'hffceff4c, "demand_reg");
    @(posedge i_clk);
    overhaul <= 1'b1;
    settle();
    check("regen_lim", 32'(o_current_demand), 32'hffffffb0);
    wr(`TDMS_OFS_SYM_LIMIT, 32'h1e);
    settle();
    check("sym_lim", {16'h0, o_current_limit}, 32'h1e);
    @(posedge i_clk);
    overhaul <= 1'b0;
    wr(`TDMS_OFS_TORQUE_REF, 32'h64);
    wr(`TDMS_OFS_CONTROL, 32'h2);
    settle();
    check("analog_ofs", 32'(o_torque_demand), 32'h74);
    wr(`TDMS_OFS_CONTROL, 32'h0);
    wr(`TDMS_OFS_MODE_SEL, 32'h0);
    settle();
    check("freq_path", 32'(o_freq_ref), 32'h0200);
    wr(`TDMS_OFS_KP, 32'h0400);
    wr(`TDMS_OFS_KI, 32'h7fff);
    wr(`TDMS_OFS_FREQ_MAX, 32'h40);
    slow <= 1'b1;
    wr(`TDMS_OFS_MODE_SEL, 32'h1);
    // slow load current walks one step a cycle, so the loop needs far longer
    repeat (5) settle();
    check("pi_pos", 32'(o_freq_ref), 32'h40);
    rd(`TDMS_OFS_FREQ_REF, 32'h40, "freq_reg");
    wr(`TDMS_OFS_TORQUE_REF, 32'hff38);
    repeat (5) settle();
    check("pi_neg", 32'(o_freq_ref), 32'hffffffc0);
    for (int m = 0; m < 3; m++) begin
      wr(`TDMS_OFS_CONTROL, 32'(m << 2) | 32'h1);
      @(posedge i_clk);
      i_run <= 1'b1;
      settle();
      check("bypass", 32'(o_ramp_bypass), 32'h1);
      @(posedge i_clk);
      i_run <= 1'b0;
      wait_stop(m);
      settle();
    end
    @(posedge i_clk);
    i_run <= 1'b1;
    settle();
    @(posedge i_clk);
    i_run <= 1'b0;
    i_disabled <= 1'b1;
    repeat (10) begin
      @(posedge i_clk);
      #1 check("no_stop", 32'(o_stop_start), 32'h0);
    end
    stop_test();
  end
endmodule
bind tdms_top tdms_top_chk u_tdms_top_chk (.i_clk, .i_rst, .i_run, .i_disabled,
  .i_measured_speed, .o_current_demand, .o_current_limit, .o_ramp_bypass, .o_stop_start,
  .o_stop_mode, .o_ramp_preload, .o_ramp_preload_value);
